// [verilog/nfh_pkg.sv]
// nfh_pkg: constants for the nand flash host controller
// assumes a 200 MHz system clock; all pin timing is counted in clock cycles
package nfh_pkg;
  localparam int CLK_PERIOD_NS = 5;
  // strobe phase and write-to-read/write-to-busy delay times in ns, as printed minimums
  localparam int T_WP_NS       = 12;
  localparam int T_WH_NS       = 10;
  localparam int T_RP_NS       = 12;
  localparam int T_REH_NS      = 10;
  localparam int T_WHR_NS      = 60;
  localparam int T_WB_NS       = 100;
  // least times round up
  localparam int WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WH_CYC  = (T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC  = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REH_CYC = (T_REH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WHR_CYC = (T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WB_CYC  = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W   = 8;
  // array geometry
  localparam int PAGE_BYTES  = 4352;
  localparam int MAIN_BYTES  = 4096;
  localparam int SPARE_BYTES = 256;
  localparam int PAGES_PER_BLOCK = 64;
  localparam int BLOCKS      = 4096;
  localparam int COL_W       = 13;
  localparam int ROW_W       = 18;
  localparam int ADDR_CYCLES = 5;
  // command codes
  localparam logic [7:0] CMD_READ1      = 8'h00;
  localparam logic [7:0] CMD_READ2      = 8'h30;
  localparam logic [7:0] CMD_COLOUT1    = 8'h05;
  localparam logic [7:0] CMD_COLOUT2    = 8'he0;
  localparam logic [7:0] CMD_RDCACHE    = 8'h31;
  localparam logic [7:0] CMD_RDLAST     = 8'h3f;
  localparam logic [7:0] CMD_DATAIN     = 8'h80;
  localparam logic [7:0] CMD_PROG       = 8'h10;
  localparam logic [7:0] CMD_COLIN      = 8'h85;
  localparam logic [7:0] CMD_PROGCACHE  = 8'h15;
  localparam logic [7:0] CMD_MPLANE1    = 8'h11;
  localparam logic [7:0] CMD_DATAIN2    = 8'h81;
  localparam logic [7:0] CMD_COPYREAD   = 8'h3a;
  localparam logic [7:0] CMD_COPYPROG   = 8'h8c;
  localparam logic [7:0] CMD_ERASE1     = 8'h60;
  localparam logic [7:0] CMD_ERASE2     = 8'hd0;
  localparam logic [7:0] CMD_ID         = 8'h90;
  localparam logic [7:0] CMD_STATUS     = 8'h70;
  localparam logic [7:0] CMD_STATUS_MP  = 8'h71;
  localparam logic [7:0] CMD_RESET      = 8'hff;
  // status bits
  localparam int STAT_FAIL_BIT  = 0;
  localparam int STAT_READY_BIT = 6;
  // host op codes on the user port
  typedef enum logic [2:0] {
    NFH_OP_CMD,
    NFH_OP_ADDR,
    NFH_OP_WDATA,
    NFH_OP_RDATA,
    NFH_OP_WAITRDY
  } nfh_op_e;
endpackage : nfh_pkg

// [verilog/nfh_strobe.sv]
// nfh_strobe: one strobe pulse of programmable low and high phase
// assumes the caller holds start for one cycle while idle
`timescale 1ns/1ps
module nfh_strobe #(
  parameter int LOW_CYC  = 3,
  parameter int HIGH_CYC = 2,
  parameter int CNT_W    = 8
) (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic reset_n_in,
  // control
  input  wire logic start_in,
  output logic      busy_out,
  output logic      strobe_n_out,
  output logic      rise_out
);
  typedef struct packed {
    logic             low;
    logic             high;
    logic [CNT_W-1:0] cnt;
  } nfh_strobe_s;

  nfh_strobe_s st_q;
  nfh_strobe_s st_d;

  always_comb begin
    st_d     = st_q;
    rise_out = 1'b0;
    if (st_q.low) begin
      if (st_q.cnt == CNT_W'(LOW_CYC - 1)) begin
        st_d.low  = 1'b0;
        st_d.high = 1'b1;
        st_d.cnt  = '0;
        rise_out  = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + 1'b1;
      end
    end else if (st_q.high) begin
      if (st_q.cnt == CNT_W'(HIGH_CYC - 1)) begin
        st_d.high = 1'b0;
      end else begin
        st_d.cnt = st_q.cnt + 1'b1;
      end
    end else if (start_in) begin
      st_d.low = 1'b1;
      st_d.cnt = '0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign busy_out     = st_q.low | st_q.high;
  assign strobe_n_out = ~st_q.low;
endmodule : nfh_strobe

// [verilog/nfh_host.sv]
// Function
// - drive command latch high with the byte, then raise write strobe to latch it.
// - drive address latch high with the byte, then raise write strobe to latch it.
// - a full address takes five address-latch write cycles.
// - cycle one column bits 0-7, cycle two bits 8-12, top three low.
// - row bits 0-17 over cycles three to five, upper six bits of five low.
// - encode command, address, data-in and data-out cycles by the latch table.
// - during read busy with chip select low, hold both strobes high; only ST_WAIT holds them, a request taken while busy still pulses a strobe.
// - end cached multi-page with 81/10; after 81/15 poll status bit 6, then ff.
//
// nfh_host: sequences single pin cycles on a byte-wide nand flash
// assumes flash pins are sampled synchronous to clock_in; ready/busy is pulled up outside
`timescale 1ns/1ps
module nfh_host
  import nfh_pkg::*;
#(
  parameter int ADDR_CYCLES_P = nfh_pkg::ADDR_CYCLES
) (
  // clock and reset
  input  wire logic            clock_in,
  input  wire logic            reset_n_in,
  // user request port
  input  wire logic            req_valid_in,
  output logic                 req_ready_out,
  input  wire nfh_pkg::nfh_op_e req_op_in,
  input  wire logic [7:0]      req_byte_in,
  input  wire logic [nfh_pkg::COL_W-1:0] req_col_in,
  input  wire logic [nfh_pkg::ROW_W-1:0] req_row_in,
  input  wire logic            req_row_only_in,
  input  wire logic            select_in,
  input  wire logic            write_enable_in,
  // user answer port
  output logic                 rsp_valid_out,
  output logic [7:0]           rsp_byte_out,
  output logic                 flash_ready_out,
  // flash pins
  output logic                 chip_sel_n_out,
  output logic                 cmd_latch_out,
  output logic                 addr_latch_out,
  output logic                 write_strobe_n_out,
  output logic                 output_strobe_n_out,
  output logic                 write_prot_n_out,
  input  wire logic            ready_busy_n_in,
  input  wire logic [7:0]      byte_port_in,
  output logic [7:0]           byte_port_out,
  output logic                 byte_port_oe_out
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WRITE,
    ST_ADDR,
    ST_READ,
    ST_GAP,
    ST_WAIT
  } nfh_state_e;

  typedef struct packed {
    nfh_state_e       state;
    nfh_op_e          op;
    logic [7:0]       dout;
    logic [39:0]      abytes;
    logic [2:0]       aidx;
    logic [2:0]       alast;
    logic [CNT_W-1:0] cnt;
    logic             rvalid;
    logic [7:0]       rbyte;
    logic             cs_n;
    logic             cle;
    logic             ale;
    logic             wp_n;
    logic             oe;
  } nfh_host_s;

  nfh_host_s st_q;
  nfh_host_s st_d;

  logic we_start;
  logic we_busy;
  logic we_rise;
  logic re_start;
  logic re_busy;
  logic re_rise;
  logic rdy;

  // pack column then row into the five address bytes, unused top bits held low
  function automatic logic [39:0] pack_addr(input logic [COL_W-1:0] col,
                                            input logic [ROW_W-1:0] row);
    pack_addr = {6'h00, row, 3'h0, col};
  endfunction : pack_addr

  assign rdy = ready_busy_n_in;

  nfh_strobe #(.LOW_CYC(WP_CYC), .HIGH_CYC(WH_CYC), .CNT_W(CNT_W)) u_we (
    .clock_in     (clock_in),
    .reset_n_in   (reset_n_in),
    .start_in     (we_start),
    .busy_out     (we_busy),
    .strobe_n_out (write_strobe_n_out),
    .rise_out     (we_rise)
  );

  nfh_strobe #(.LOW_CYC(RP_CYC), .HIGH_CYC(REH_CYC), .CNT_W(CNT_W)) u_re (
    .clock_in     (clock_in),
    .reset_n_in   (reset_n_in),
    .start_in     (re_start),
    .busy_out     (re_busy),
    .strobe_n_out (output_strobe_n_out),
    .rise_out     (re_rise)
  );

  always_comb begin
    st_d          = st_q;
    st_d.rvalid   = 1'b0;
    st_d.wp_n     = write_enable_in;
    we_start      = 1'b0;
    re_start      = 1'b0;
    req_ready_out = 1'b0;
    unique case (st_q.state)
      ST_IDLE: begin
        req_ready_out = 1'b1;
        // chip select only rises while ready; busy flash keeps it as it was unless a request pulls it low
        if (rdy) begin
          st_d.cs_n = ~select_in;
        end
        if (req_valid_in) begin
          st_d.op   = req_op_in;
          st_d.dout = req_byte_in;
          st_d.cs_n = 1'b0;
          st_d.cnt  = '0;
          unique case (req_op_in)
            NFH_OP_CMD: begin
              st_d.cle   = 1'b1;
              st_d.ale   = 1'b0;
              st_d.oe    = 1'b1;
              st_d.state = ST_WRITE;
            end
            NFH_OP_ADDR: begin
              st_d.abytes = pack_addr(req_col_in, req_row_in);
              // first byte is on the port before the strobe starts, so it stands the whole low phase
              st_d.dout   = req_row_only_in ? req_row_in[7:0] : req_col_in[7:0];
              // erase sends only the row bytes, starting at cycle three
              st_d.aidx   = req_row_only_in ? 3'd2 : 3'd0;
              st_d.alast  = 3'(ADDR_CYCLES_P - 1);
              st_d.cle    = 1'b0;
              st_d.ale    = 1'b1;
              st_d.oe     = 1'b1;
              st_d.state  = ST_ADDR;
            end
            NFH_OP_WDATA: begin
              st_d.cle   = 1'b0;
              st_d.ale   = 1'b0;
              st_d.oe    = 1'b1;
              st_d.state = ST_WRITE;
            end
            NFH_OP_RDATA: begin
              st_d.cle   = 1'b0;
              st_d.ale   = 1'b0;
              st_d.oe    = 1'b0;
              st_d.state = ST_READ;
            end
            NFH_OP_WAITRDY: begin
              st_d.state = ST_WAIT;
            end
            default: begin
              st_d.state = ST_IDLE;
            end
          endcase
        end
      end
      ST_WRITE: begin
        // latches settle one cycle before the strobe falls
        if (!we_busy && st_q.cnt == '0) begin
          we_start = 1'b1;
          st_d.cnt = CNT_W'(1);
        end else if (st_q.cnt != '0 && !we_busy) begin
          st_d.cle   = 1'b0;
          st_d.ale   = 1'b0;
          st_d.cnt   = '0;
          st_d.state = (st_q.op == NFH_OP_CMD) ? ST_GAP : ST_IDLE;
        end
      end
      ST_ADDR: begin
        if (!we_busy && st_q.cnt == '0) begin
          we_start = 1'b1;
          st_d.cnt = CNT_W'(1);
        end else if (st_q.cnt != '0 && !we_busy) begin
          st_d.cnt = '0;
          if (st_q.aidx == st_q.alast) begin
            st_d.ale   = 1'b0;
            st_d.state = ST_IDLE;
          end else begin
            // next byte moves only while the strobe is idle
            st_d.aidx = st_q.aidx + 3'd1;
            st_d.dout = st_q.abytes[8*(st_q.aidx + 3'd1) +: 8];
          end
        end
      end
      ST_READ: begin
        if (!re_busy && st_q.cnt == '0) begin
          re_start = 1'b1;
          st_d.cnt = CNT_W'(1);
        end else if (re_rise) begin
          st_d.rbyte  = byte_port_in;
          st_d.rvalid = 1'b1;
        end else if (st_q.cnt != '0 && !re_busy) begin
          st_d.cnt   = '0;
          st_d.state = ST_IDLE;
        end
      end
      ST_GAP: begin
        // covers write-to-busy and write-to-read delays after any command
        st_d.oe = 1'b0;
        if (st_q.cnt == CNT_W'(((WB_CYC > WHR_CYC) ? WB_CYC : WHR_CYC) - 1)) begin
          st_d.cnt   = '0;
          st_d.state = ST_IDLE;
        end else begin
          st_d.cnt = st_q.cnt + 1'b1;
        end
      end
      ST_WAIT: begin
        // strobes stay high while waiting on a busy flash
        st_d.oe = 1'b0;
        if (rdy) begin
          st_d.state = ST_IDLE;
        end
      end
      default: begin
        st_d.state = ST_IDLE;
      end
    endcase
    if (st_q.state == ST_IDLE && !req_valid_in) begin
      st_d.oe = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      st_q       <= '0;
      st_q.state <= ST_IDLE;
      st_q.op    <= NFH_OP_CMD;
      st_q.cs_n  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign rsp_valid_out    = st_q.rvalid;
  assign rsp_byte_out     = st_q.rbyte;
  assign flash_ready_out  = rdy;
  assign chip_sel_n_out   = st_q.cs_n;
  assign cmd_latch_out    = st_q.cle;
  assign addr_latch_out   = st_q.ale;
  assign write_prot_n_out = st_q.wp_n;
  assign byte_port_out    = st_q.dout;
  assign byte_port_oe_out = st_q.oe;
endmodule : nfh_host

// [tb/nfh_host_chk.sv]
// nfh_host_chk: pin-level checks on the flash side of nfh_host
// assumes it is bound into nfh_host; one clock domain
`timescale 1ns/1ps
module nfh_host_chk (
  input wire logic       clock_in,
  input wire logic       reset_n_in,
  input wire logic       rsp_valid_out,
  input wire logic       chip_sel_n_out,
  input wire logic       cmd_latch_out,
  input wire logic       addr_latch_out,
  input wire logic       write_strobe_n_out,
  input wire logic       output_strobe_n_out,
  input wire logic       ready_busy_n_in,
  input wire logic [7:0] byte_port_out,
  input wire logic       byte_port_oe_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  sequence we_low3;
    !write_strobe_n_out[*3] ##1 write_strobe_n_out;
  endsequence
  sequence re_low3;
    !output_strobe_n_out[*3] ##1 output_strobe_n_out;
  endsequence
  we_width_a: assert property ($fell(write_strobe_n_out) |-> we_low3)
    else $error("write strobe low phase wrong");
  re_width_a: assert property ($fell(output_strobe_n_out) |-> re_low3)
    else $error("read strobe low phase wrong");
  latch_excl_a: assert property (!write_strobe_n_out |-> !(cmd_latch_out && addr_latch_out))
    else $error("both latches high in a write");
  latch_hold_a: assert property (!write_strobe_n_out |->
    $stable(cmd_latch_out) && $stable(addr_latch_out) && $stable(byte_port_out))
    else $error("latch or byte moved under write strobe");
  we_drive_a: assert property ($rose(write_strobe_n_out) |->
    byte_port_oe_out && !chip_sel_n_out && $stable(byte_port_out))
    else $error("byte not driven at write strobe rise");
  port_free_a: assert property (!output_strobe_n_out |-> !byte_port_oe_out)
    else $error("host drives port during read strobe");
  rd_cycle_a: assert property (!output_strobe_n_out |-> write_strobe_n_out &&
    !cmd_latch_out && !addr_latch_out && !chip_sel_n_out)
    else $error("bad pin state during read strobe");
  rsp_after_a: assert property ($rose(output_strobe_n_out) |-> rsp_valid_out)
    else $error("no read answer after read strobe");
  busy_quiet_a: assert property (!ready_busy_n_in && !chip_sel_n_out |->
    write_strobe_n_out && output_strobe_n_out)
    else $error("strobe moved while flash busy");
endmodule : nfh_host_chk

bind nfh_host nfh_host_chk nfh_host_chk_inst (.clock_in, .reset_n_in, .rsp_valid_out,
  .chip_sel_n_out, .cmd_latch_out, .addr_latch_out, .write_strobe_n_out,
  .output_strobe_n_out, .ready_busy_n_in, .byte_port_out, .byte_port_oe_out);

// [tb/nfh_flash_model.sv]
// nfh_flash_model: behavioural byte-wide nand flash seen from its pins
// assumes pins move only on host clock edges; ready/busy pull-up is outside
`timescale 1ns/1ps
module nfh_flash_model #(
  parameter logic [7:0] ID_BYTE  = 8'h5a, // arbitrary value
  parameter int         BUSY_CYC = 40
) (
  input  wire logic       clock_in,
  input  wire logic       reset_n_in,
  input  wire logic       chip_sel_n_in,
  input  wire logic       cmd_latch_in,
  input  wire logic       addr_latch_in,
  input  wire logic       write_strobe_n_in,
  input  wire logic       output_strobe_n_in,
  input  wire logic       write_prot_n_in,
  input  wire logic [7:0] byte_port_in,
  output logic [7:0]      byte_port_out,
  output logic            byte_port_oe_out,
  output logic            busy_pull_out
);
  import nfh_pkg::*;
  logic [7:0]  cmd_q, dout_q;
  logic [12:0] col_q;
  logic [17:0] row_q;
  logic [2:0]  acnt_q;
  logic        fail_q, we_p, re_p;
  int          bcnt_q;
  wire we_rise = !chip_sel_n_in && write_strobe_n_in && !we_p;
  wire idle = bcnt_q == 0;
  always_ff @(posedge clock_in) begin
    we_p <= write_strobe_n_in;
    re_p <= output_strobe_n_in;
    if (!idle) bcnt_q <= bcnt_q - 1;
    if (!reset_n_in) begin
      cmd_q <= 8'h00;
      acnt_q <= 3'h0;
      bcnt_q <= 0;
      fail_q <= 1'b0;
    end else if (we_rise && cmd_latch_in) begin
      if ((idle && byte_port_in inside {8'h00, 8'h30, 8'h05, 8'he0, 8'h31, 8'h3f, 8'h80,
          8'h10, 8'h85, 8'h15, 8'h11, 8'h81, 8'h3a, 8'h8c, 8'h60, 8'hd0, 8'h90}) ||
          byte_port_in inside {8'h70, 8'h71, 8'hff}) begin
        cmd_q <= byte_port_in;
        acnt_q <= (byte_port_in == 8'h60) ? 3'h2 : 3'h0;
        if (byte_port_in inside {8'h30, 8'h31, 8'h3f}) bcnt_q <= BUSY_CYC;
        if (byte_port_in inside {8'h10, 8'h15, 8'h11, 8'hd0}) begin
          // second plane keeps any failure of the first
          fail_q <= !write_prot_n_in | ((cmd_q == 8'h81) & fail_q);
          if (write_prot_n_in) bcnt_q <= BUSY_CYC;
        end
      end
    end else if (we_rise && addr_latch_in) begin
      acnt_q <= acnt_q + 3'h1;
      case (acnt_q)
        3'h0: col_q[7:0] <= byte_port_in;
        3'h1: col_q[12:8] <= byte_port_in[4:0];
        3'h2: row_q[7:0] <= byte_port_in;
        3'h3: row_q[15:8] <= byte_port_in;
        default: row_q[17:16] <= byte_port_in[1:0];
      endcase
    end else if (!chip_sel_n_in && !output_strobe_n_in && re_p) begin
      dout_q <= (cmd_q inside {8'h70, 8'h71}) ? {1'b0, idle, 5'h0, fail_q} :
                (cmd_q == 8'h90) ? ID_BYTE : col_q[7:0];
      col_q <= (col_q == 13'(PAGE_BYTES - 1)) ? 13'h0 : col_q + 13'h1;
    end
  end
  // port driven only while selected, latches low and read strobe low
  assign byte_port_oe_out = !chip_sel_n_in && !cmd_latch_in && !addr_latch_in &&
                            !output_strobe_n_in;
  assign byte_port_out = dout_q;
  assign busy_pull_out = !idle;
endmodule : nfh_flash_model

// [tb/nfh_host_bench.sv]
// nfh_host_bench: drives nfh_host against the flash model and judges read-back
// assumes the checker binds itself; inputs change on the falling clock edge
`timescale 1ns/1ps
module nfh_host_bench;
  import nfh_pkg::*;
  localparam logic [7:0] ID = 8'h3c; // arbitrary value
  logic clock_in = 1'b0, reset_n_in = 1'b0, req_valid_in = 1'b0, req_row_only_in = 1'b0;
  logic select_in = 1'b1, write_enable_in = 1'b0, saw_busy = 1'b0;
  nfh_op_e req_op_in = NFH_OP_CMD;
  logic [7:0] req_byte_in = 8'h00, rsp_byte_out, byte_port_out, m_dq, last_rsp;
  logic [12:0] req_col_in = 13'h0;
  logic [17:0] req_row_in = 18'h0;
  logic req_ready_out, rsp_valid_out, flash_ready_out, chip_sel_n_out, cmd_latch_out;
  logic addr_latch_out, write_strobe_n_out, output_strobe_n_out, write_prot_n_out;
  logic byte_port_oe_out, m_oe, m_pull;
  int errors = 0, checked = 0;
  wire ready_busy_n = !m_pull;
  // undriven port shows the inverse of the host byte, never a stale value
  wire [7:0] port_w = m_oe ? m_dq : byte_port_oe_out ? byte_port_out : ~byte_port_out;
  initial forever #2.5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    if (rsp_valid_out === 1'b1) last_rsp <= rsp_byte_out;
    if (m_pull) saw_busy <= 1'b1;
  end
  nfh_host nfh_host_inst (.clock_in, .reset_n_in, .req_valid_in, .req_ready_out, .req_op_in,
    .req_byte_in, .req_col_in, .req_row_in, .req_row_only_in, .select_in, .write_enable_in,
    .rsp_valid_out, .rsp_byte_out, .flash_ready_out, .chip_sel_n_out, .cmd_latch_out,
    .addr_latch_out, .write_strobe_n_out, .output_strobe_n_out, .write_prot_n_out,
    .ready_busy_n_in(ready_busy_n), .byte_port_in(port_w), .byte_port_out, .byte_port_oe_out);
  nfh_flash_model #(.ID_BYTE(ID)) nfh_flash_model_inst (.clock_in, .reset_n_in,
    .chip_sel_n_in(chip_sel_n_out), .cmd_latch_in(cmd_latch_out),
    .addr_latch_in(addr_latch_out), .write_strobe_n_in(write_strobe_n_out),
    .output_strobe_n_in(output_strobe_n_out), .write_prot_n_in(write_prot_n_out),
    .byte_port_in(port_w), .byte_port_out(m_dq), .byte_port_oe_out(m_oe),
    .busy_pull_out(m_pull));
  task automatic print_verdict;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic req(input nfh_op_e op, input logic [7:0] b, input logic [17:0] row = 0,
                     input logic [12:0] col = 0, input logic ro = 1'b0);
    int n;
    {req_op_in, req_byte_in, req_row_in, req_col_in, req_row_only_in} = {op, b, row, col, ro};
    req_valid_in = 1'b1;
    for (n = 0; n < 3000 && req_ready_out !== 1'b1; n++) @(negedge clock_in);
    @(negedge clock_in);
    req_valid_in = 1'b0;
    for (n = 0; n < 3000 && req_ready_out !== 1'b1; n++) @(negedge clock_in);
    if (n == 3000) begin
      errors++;
      print_verdict();
    end
  endtask : req
  task automatic rd(input logic [7:0] exp);
    req(NFH_OP_RDATA, 8'h00);
    repeat (2) @(negedge clock_in);
    chk(last_rsp, exp);
  endtask : rd
  // power-on read needs no leading 00; checks address layout and column advance
  task automatic t_read;
    req(NFH_OP_ADDR, 8'h00, 18'h2a5c3, 13'h1005);
    chk(nfh_flash_model_inst.col_q, 13'h1005);
    chk(nfh_flash_model_inst.row_q, 18'h2a5c3);
    req(NFH_OP_CMD, 8'h30);
    req(NFH_OP_WAITRDY, 8'h00);
    rd(8'h05);
    rd(8'h06);
    req(NFH_OP_CMD, 8'h42);
    rd(8'h07);
    req(NFH_OP_CMD, 8'h90);
    rd(ID);
  endtask : t_read
  task automatic t_prog(input logic wp_ok, input logic [7:0] stat);
    write_enable_in = wp_ok;
    saw_busy = 1'b0;
    repeat (25) @(negedge clock_in);
    req(NFH_OP_CMD, 8'h80);
    req(NFH_OP_ADDR, 8'h00, 18'h00040, 13'h0000);
    req(NFH_OP_WDATA, 8'ha5);
    req(NFH_OP_CMD, 8'h10);
    req(NFH_OP_WAITRDY, 8'h00);
    chk(saw_busy, wp_ok);
    req(NFH_OP_CMD, 8'h70);
    rd(stat);
  endtask : t_prog
  // first plane fails under write protect; the final status must still flag it
  task automatic t_mplane;
    write_enable_in = 1'b0;
    repeat (25) @(negedge clock_in);
    req(NFH_OP_CMD, 8'h80);
    req(NFH_OP_ADDR, 8'h00, 18'h00080, 13'h0000);
    req(NFH_OP_WDATA, 8'h3c);
    req(NFH_OP_CMD, 8'h11);
    req(NFH_OP_WAITRDY, 8'h00);
    write_enable_in = 1'b1;
    repeat (25) @(negedge clock_in);
    req(NFH_OP_CMD, 8'h81);
    req(NFH_OP_ADDR, 8'h00, 18'h000c0, 13'h0000);
    req(NFH_OP_WDATA, 8'hc3);
    req(NFH_OP_CMD, 8'h10);
    req(NFH_OP_WAITRDY, 8'h00);
    req(NFH_OP_CMD, 8'h71);
    rd(8'h41);
  endtask : t_mplane
  task automatic t_erase;
    req(NFH_OP_CMD, 8'h60);
    req(NFH_OP_ADDR, 8'h00, 18'h3ffc0, 13'h0000, 1'b1);
    req(NFH_OP_CMD, 8'hd0);
    select_in = 1'b0;
    repeat (3) @(negedge clock_in);
    chk(flash_ready_out, 1'b0);
    chk(chip_sel_n_out, 1'b0);
    req(NFH_OP_WAITRDY, 8'h00);
    chk(nfh_flash_model_inst.row_q, 18'h3ffc0);
    chk(flash_ready_out, 1'b1);
    repeat (2) @(negedge clock_in);
    chk(chip_sel_n_out, 1'b1);
    select_in = 1'b1;
  endtask : t_erase
  initial begin
    repeat (2) @(negedge clock_in);
    chk({chip_sel_n_out, write_strobe_n_out, output_strobe_n_out, write_prot_n_out,
         byte_port_oe_out, cmd_latch_out, addr_latch_out, rsp_valid_out}, 8'he0);
    @(negedge clock_in);
    reset_n_in = 1'b1;
    t_read();
    t_prog(1'b0, 8'h41);
    t_prog(1'b1, 8'h40);
    t_mplane();
    t_erase();
    print_verdict();
  end
endmodule : nfh_host_bench
